/* rtl/tcs_channel.sv */
// Contract
// - line b action on compare c match
// - line b action on external event
// - line b action on software trigger
// - live count readable, upper bits zero
// - a and b writable only in waveform
// - compare c read/write in both modes
// - overflow flag held until status read
// - load overrun flag, capture mode only
// - match a/b flags, waveform mode only
// - match c flag in both modes
// - load a/b flags, capture mode only
// - external trigger flag held until read
// - status read clears event flags
// - bit 16 shows counter clock enabled
// - bit 17 mirrors line a
// - bit 18 mirrors line b
// - enable register sets mask bits
// - disable register clears mask bits
// - mode bit: 0 capture, 1 waveform
// - mask register reads enabled interrupts
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps

module tcs_channel (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // timer io lines and external event
  input  wire logic        io_line_a_i,
  output logic             io_line_a_o,
  output logic             io_line_a_oe_o,
  input  wire logic        io_line_b_i,
  output logic             io_line_b_o,
  output logic             io_line_b_oe_o,
  input  wire logic        ext_event_i,
  // interrupt
  output logic             irq_o
);

  tcs_pkg::tcs_state_t st_q;
  tcs_pkg::tcs_state_t st_d;

  logic        acc;       // first access cycle: reads sampled here
  logic        done;      // completing edge: writes take effect here
  logic [11:0] adr;
  logic        hit;
  logic [7:0]  ev;
  logic        ma, mb, mc, ovf, cap_a, cap_b, ext_ev, sw_ev;
  logic [31:0] sr_word;
  logic [31:0] rdata;

  // applies one two-bit line action to the current level
  function automatic logic line_act(input logic [1:0] code, input logic lvl);
    logic r;
    r = lvl;
    case (code)
      tcs_pkg::ACT_SET:   r = 1'b1;
      tcs_pkg::ACT_CLEAR: r = 1'b0;
      tcs_pkg::ACT_TOG:   r = ~lvl;
      default:            r = lvl;
    endcase
    return r;
  endfunction : line_act

  // ************************************************************
  // bus decode and events
  // ************************************************************

  // one wait state keeps pready and prdata straight from flops
  always_comb begin
    acc    = psel_i & penable_i & ~st_q.pready;
    done   = psel_i & penable_i & st_q.pready;
    adr    = paddr_i;
    hit    = (adr == tcs_pkg::OFS_CTRL) | (adr == tcs_pkg::OFS_COUNT) |
             (adr == tcs_pkg::OFS_CMP_A) | (adr == tcs_pkg::OFS_CMP_B) |
             (adr == tcs_pkg::OFS_CMP_C) | (adr == tcs_pkg::OFS_SR) |
             (adr == tcs_pkg::OFS_IER) | (adr == tcs_pkg::OFS_IDR) |
             (adr == tcs_pkg::OFS_IMR);
    // compares only fire while the counter clock runs
    ma     = st_q.clk_on & (st_q.count == st_q.cmp_a);
    mb     = st_q.clk_on & (st_q.count == st_q.cmp_b);
    mc     = st_q.clk_on & (st_q.count == st_q.cmp_c);
    ovf    = st_q.clk_on & (st_q.count == tcs_pkg::CNT_MAX);
    // capture: rising edge of line a loads a, falling edge loads b
    cap_a  = ~st_q.wave & st_q.sync_a[1] & ~st_q.sync_a[2];
    cap_b  = ~st_q.wave & ~st_q.sync_a[1] & st_q.sync_a[2];
    ext_ev = st_q.sync_e[1] & ~st_q.sync_e[2];
    sw_ev  = done & pwrite_i & (adr == tcs_pkg::OFS_CTRL) & pwdata_i[tcs_pkg::CTRL_SW_TRIG];
    ev     = 8'h00;
    ev[tcs_pkg::SR_OVF]  = ovf;
    ev[tcs_pkg::SR_LOVR] = (cap_a & st_q.a_unread) | (cap_b & st_q.b_unread);
    ev[tcs_pkg::SR_MA]   = st_q.wave & ma;
    ev[tcs_pkg::SR_MB]   = st_q.wave & mb;
    ev[tcs_pkg::SR_MC]   = mc;
    ev[tcs_pkg::SR_LDA]  = cap_a;
    ev[tcs_pkg::SR_LDB]  = cap_b;
    ev[tcs_pkg::SR_ETRG] = ext_ev;
  end

  // ************************************************************
  // read data
  // ************************************************************

  // status word masks flags by mode; mirrors follow pin or drive level
  always_comb begin
    sr_word = 32'h0000_0000;
    sr_word[7:0] = st_q.flags &
                   (st_q.wave ? tcs_pkg::WAVE_FLAG_MASK : tcs_pkg::CAP_FLAG_MASK);
    sr_word[tcs_pkg::SR_CLK_ON]   = st_q.clk_on;
    sr_word[tcs_pkg::SR_MIRROR_A] = st_q.wave ? st_q.line_a : st_q.sync_a[1];
    sr_word[tcs_pkg::SR_MIRROR_B] = st_q.wave ? st_q.line_b : st_q.sync_b[1];
    rdata = 32'h0000_0000;
    case (adr)
      tcs_pkg::OFS_CTRL: begin
        rdata[tcs_pkg::CTRL_WAVE]   = st_q.wave;
        rdata[tcs_pkg::CTRL_CLK_ON] = st_q.clk_on;
        rdata[tcs_pkg::CTRL_BC_LSB +: 2] = st_q.b_on_c;
        rdata[tcs_pkg::CTRL_BE_LSB +: 2] = st_q.b_on_e;
        rdata[tcs_pkg::CTRL_BS_LSB +: 2] = st_q.b_on_s;
      end
      tcs_pkg::OFS_COUNT: rdata = {16'h0000, st_q.count};
      tcs_pkg::OFS_CMP_A: rdata = {16'h0000, st_q.cmp_a};
      tcs_pkg::OFS_CMP_B: rdata = {16'h0000, st_q.cmp_b};
      tcs_pkg::OFS_CMP_C: rdata = {16'h0000, st_q.cmp_c};
      tcs_pkg::OFS_SR:  rdata = sr_word;
      tcs_pkg::OFS_IMR: rdata = {24'h00_0000, st_q.imr};
      default:          rdata = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************

  always_comb begin
    st_d = st_q;
    // two stages before any logic looks at a pin, third for edges
    st_d.sync_a = {st_q.sync_a[1], st_q.sync_a[0], io_line_a_i};
    st_d.sync_b = {st_q.sync_b[1], st_q.sync_b[0], io_line_b_i};
    st_d.sync_e = {st_q.sync_e[1], st_q.sync_e[0], ext_event_i};
    st_d.pready  = acc;
    st_d.pslverr = acc & ~hit;
    st_d.prdata  = (acc & ~pwrite_i) ? rdata : 32'h0000_0000;

    // free running counter, wraps past the top
    if (st_q.clk_on) begin
      st_d.count = st_q.count + 16'h0001;
    end

    // captures; a pending unread marks the next load as overrun
    if (cap_a) begin
      st_d.cmp_a    = st_q.count;
      st_d.a_unread = 1'b1;
    end
    if (cap_b) begin
      st_d.cmp_b    = st_q.count;
      st_d.b_unread = 1'b1;
    end
    if (acc & ~pwrite_i & (adr == tcs_pkg::OFS_CMP_A) & ~cap_a) begin
      st_d.a_unread = 1'b0;
    end
    if (acc & ~pwrite_i & (adr == tcs_pkg::OFS_CMP_B) & ~cap_b) begin
      st_d.b_unread = 1'b0;
    end

    // read of status clears, a same-cycle event still lands
    if (acc & ~pwrite_i & (adr == tcs_pkg::OFS_SR)) begin
      st_d.flags = ev;
    end else begin
      st_d.flags = st_q.flags | ev;
    end

    // line a: set on a match, cleared on c match (waveform only)
    if (st_q.wave) begin
      if (ma) st_d.line_a = 1'b1;
      if (mc) st_d.line_a = 1'b0;
    end

    // line b: later actions override, software trigger strongest
    if (st_q.wave) begin
      st_d.line_b = st_q.line_b;
      if (mc)     st_d.line_b = line_act(st_q.b_on_c, st_q.line_b);
      if (ext_ev) st_d.line_b = line_act(st_q.b_on_e, st_d.line_b);
      // the trigger rides on the same write, so its new action code applies
      if (sw_ev)  st_d.line_b = line_act(pwdata_i[tcs_pkg::CTRL_BS_LSB +: 2], st_d.line_b);
    end

    // register writes at the completing edge
    if (done & pwrite_i) begin
      case (adr)
        tcs_pkg::OFS_CTRL: begin
          st_d.wave   = pwdata_i[tcs_pkg::CTRL_WAVE];
          st_d.clk_on = pwdata_i[tcs_pkg::CTRL_CLK_ON];
          st_d.b_on_c = pwdata_i[tcs_pkg::CTRL_BC_LSB +: 2];
          st_d.b_on_e = pwdata_i[tcs_pkg::CTRL_BE_LSB +: 2];
          st_d.b_on_s = pwdata_i[tcs_pkg::CTRL_BS_LSB +: 2];
        end
        tcs_pkg::OFS_CMP_A: begin
          if (st_q.wave) st_d.cmp_a = pwdata_i[15:0];
        end
        tcs_pkg::OFS_CMP_B: begin
          if (st_q.wave) st_d.cmp_b = pwdata_i[15:0];
        end
        tcs_pkg::OFS_CMP_C: st_d.cmp_c = pwdata_i[15:0];
        tcs_pkg::OFS_IER: st_d.imr = st_q.imr | pwdata_i[7:0];
        tcs_pkg::OFS_IDR: st_d.imr = st_q.imr & ~pwdata_i[7:0];
        default: ;
      endcase
    end

    // irq follows the flags that will stand after this edge
    st_d.irq = |(st_d.flags & st_d.imr);
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q        <= '0;
      st_q.cmp_a  <= tcs_pkg::REG_RST;
      st_q.cmp_b  <= tcs_pkg::REG_RST;
      st_q.cmp_c  <= tcs_pkg::REG_RST;
      st_q.flags  <= tcs_pkg::FLAG_RST;
      st_q.imr    <= tcs_pkg::FLAG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  // lines are driven only in waveform mode
  always_comb begin
    prdata_o       = st_q.prdata;
    pready_o       = st_q.pready;
    pslverr_o      = st_q.pslverr;
    io_line_a_o    = st_q.line_a;
    io_line_a_oe_o = st_q.wave;
    io_line_b_o    = st_q.line_b;
    io_line_b_oe_o = st_q.wave;
    irq_o          = st_q.irq;
  end

  // ************************************************************
  // assertions
  // ************************************************************

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic sr_rd, count_rd;
  assign sr_rd    = acc & ~pwrite_i & (adr == tcs_pkg::OFS_SR);
  assign count_rd = acc & ~pwrite_i & (adr == tcs_pkg::OFS_COUNT);

  a_ovf_held: assert property ((ev[0] && !sr_rd) |=> st_q.flags[0] ##1
                               (st_q.flags[0] || $past(sr_rd)))
    else $error("overflow flag not held");
  a_sr_clear: assert property ((sr_rd && ev == 8'h00) |=> st_q.flags == 8'h00)
    else $error("status read did not clear flags");
  a_same_cycle: assert property ((sr_rd && ext_ev) |=> st_q.flags[7])
    else $error("event lost against status read");
  a_cv_value: assert property (count_rd |=> prdata_o == {16'h0000, $past(st_q.count)})
    else $error("count readback wrong");
  a_ra_locked: assert property ((done && pwrite_i && adr == tcs_pkg::OFS_CMP_A && !st_q.wave
                                 && !cap_a) |=> $stable(st_q.cmp_a))
    else $error("register a written in capture mode");
  a_rc_write: assert property ((done && pwrite_i && adr == tcs_pkg::OFS_CMP_C)
                               |=> st_q.cmp_c == $past(pwdata_i[15:0]))
    else $error("register c write lost");
  a_sr_mode: assert property ((sr_rd && st_q.wave) |=> prdata_o[1] == 1'b0 &&
                              prdata_o[6:5] == 2'h0)
    else $error("capture flags visible in waveform mode");
  a_sr_clk: assert property (sr_rd |=> prdata_o[16] == $past(st_q.clk_on))
    else $error("clock status wrong");
  a_mirror_b: assert property ((sr_rd && !st_q.wave) |=> prdata_o[18] == $past(st_q.sync_b[1]))
    else $error("line b mirror wrong");
  a_mirror_a: assert property ((sr_rd && st_q.wave) |=> prdata_o[17] == $past(st_q.line_a))
    else $error("line a mirror wrong");
  a_sw_set: assert property ((st_q.wave && sw_ev &&
                              pwdata_i[tcs_pkg::CTRL_BS_LSB +: 2] == tcs_pkg::ACT_SET)
                             |=> io_line_b_o)
    else $error("software trigger did not set line b");
  a_c_clear: assert property ((st_q.wave && mc && !ext_ev && !sw_ev &&
                               st_q.b_on_c == tcs_pkg::ACT_CLEAR) |=> !io_line_b_o)
    else $error("c match did not clear line b");
  a_ext_tog: assert property ((st_q.wave && ext_ev && !sw_ev && !mc &&
                               st_q.b_on_e == tcs_pkg::ACT_TOG)
                              |=> io_line_b_o != $past(io_line_b_o))
    else $error("external event did not toggle line b");
  a_ier_set: assert property ((done && pwrite_i && adr == tcs_pkg::OFS_IER)
                              |=> (st_q.imr & $past(pwdata_i[7:0])) == $past(pwdata_i[7:0]))
    else $error("enable write missed");
  a_idr_clr: assert property ((done && pwrite_i && adr == tcs_pkg::OFS_IDR)
                              |=> (st_q.imr & $past(pwdata_i[7:0])) == 8'h00)
    else $error("disable write missed");
  a_irq_lvl: assert property (##1 irq_o == |(st_q.flags & st_q.imr))
    else $error("irq level wrong");

endmodule : tcs_channel

/* rtl/tcs_pkg.sv */
package tcs_pkg;

  // ************************************************************
  // register map (byte addresses on the apb bus)
  // ************************************************************
  localparam logic [11:0] OFS_CTRL  = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam logic [11:0] OFS_CMP_A = 12'h014;
  localparam logic [11:0] OFS_CMP_B = 12'h018;
  localparam logic [11:0] OFS_CMP_C = 12'h01C;
  localparam logic [11:0] OFS_SR    = 12'h020;
  localparam logic [11:0] OFS_IER   = 12'h024;
  localparam logic [11:0] OFS_IDR   = 12'h028;
  localparam logic [11:0] OFS_IMR   = 12'h02C;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTRL_WAVE      = 0;
  localparam int CTRL_CLK_ON    = 1;
  localparam int CTRL_SW_TRIG   = 3;
  localparam int CTRL_BC_LSB    = 4;
  localparam int CTRL_BE_LSB    = 6;
  localparam int CTRL_BS_LSB    = 8;

  // ************************************************************
  // status fields
  // ************************************************************
  localparam int SR_OVF         = 0;
  localparam int SR_LOVR        = 1;
  localparam int SR_MA          = 2;
  localparam int SR_MB          = 3;
  localparam int SR_MC          = 4;
  localparam int SR_LDA         = 5;
  localparam int SR_LDB         = 6;
  localparam int SR_ETRG        = 7;
  localparam int SR_CLK_ON      = 16;
  localparam int SR_MIRROR_A    = 17;
  localparam int SR_MIRROR_B    = 18;
  localparam logic [7:0] CAP_FLAG_MASK  = 8'hF3;
  localparam logic [7:0] WAVE_FLAG_MASK = 8'h9D;

  // ************************************************************
  // line actions, reset values, counter limits
  // ************************************************************
  localparam logic [1:0]  ACT_NONE  = 2'h0;
  localparam logic [1:0]  ACT_SET   = 2'h1;
  localparam logic [1:0]  ACT_CLEAR = 2'h2;
  localparam logic [1:0]  ACT_TOG   = 2'h3;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [7:0]  FLAG_RST  = 8'h00;

  typedef struct packed {
    logic [2:0]  sync_a;   // [0] first stage, [1] second, [2] edge history
    logic [2:0]  sync_b;
    logic [2:0]  sync_e;
    logic        wave;
    logic        clk_on;
    logic [1:0]  b_on_c;
    logic [1:0]  b_on_e;
    logic [1:0]  b_on_s;
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cmp_c;
    logic [7:0]  flags;
    logic [7:0]  imr;
    logic        a_unread;
    logic        b_unread;
    logic        line_a;
    logic        line_b;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } tcs_state_t;

endpackage : tcs_pkg

/* tb/tcs_channel_tb.sv */
`timescale 1ns/1ps

module tcs_channel_tb;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic        clk_i   = 1'b0;
  logic        rstn_i  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd, cap_a_val;
  logic        pready, pslverr, err, irq;
  logic        a_o, a_oe, b_o, b_oe, pin_a, pin_b, evt;
  logic [15:0] count_val;
  int          miscompares = 0;
  int          check_count = 0;

  always #4 clk_i = ~clk_i;

  tcs_channel u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .io_line_a_i(pin_a), .io_line_a_o(a_o), .io_line_a_oe_o(a_oe),
    .io_line_b_i(pin_b), .io_line_b_o(b_o), .io_line_b_oe_o(b_oe), .ext_event_i(evt),
    .irq_o(irq));

  tcs_line_model u_line (
    .clk_i(clk_i), .line_a_i(a_o), .line_a_oe_i(a_oe), .line_b_i(b_o), .line_b_oe_i(b_oe),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .evt_o(evt));

  // ************************************************************
  // shared bus and compare tasks
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // request held until pready is seen high at an edge; data taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  function automatic logic [31:0] ctrl(logic w, logic c, logic s, logic [1:0] bc,
                                       logic [1:0] be, logic [1:0] bs);
    logic [31:0] v;
    v = 32'h0;
    v[tcs_pkg::CTRL_WAVE] = w;
    v[tcs_pkg::CTRL_CLK_ON] = c;
    v[tcs_pkg::CTRL_SW_TRIG] = s;
    v[tcs_pkg::CTRL_BC_LSB +: 2] = bc;
    v[tcs_pkg::CTRL_BE_LSB +: 2] = be;
    v[tcs_pkg::CTRL_BS_LSB +: 2] = bs;
    return v;
  endfunction : ctrl

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset;
    chk({28'h0, a_oe, b_oe, irq, pslverr}, 32'h0);
    rd_chk(tcs_pkg::OFS_COUNT, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_reset

  // rc parked high so the short run makes no c match
  task t_capture;
    logic [31:0] cap_b_val;
    wr(tcs_pkg::OFS_CMP_C, 32'hFFF0);
    wr(tcs_pkg::OFS_CTRL, ctrl(1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0));
    u_line.drive(1'b1, 1'b0, 1'b0);
    u_line.drive(1'b0, 1'b0, 1'b0);
    rd_chk(tcs_pkg::OFS_SR, 32'h00010060);
    u_line.drive(1'b1, 1'b1, 1'b0);
    rd_chk(tcs_pkg::OFS_SR, 32'h00070022);
    apb(1'b0, tcs_pkg::OFS_CMP_B, 32'h0);
    cap_b_val = rd;
    apb(1'b0, tcs_pkg::OFS_CMP_A, 32'h0);
    cap_a_val = rd;
    chk({31'h0, cap_a_val > cap_b_val}, 32'h1);
    chk(cap_a_val & 32'hFFFF0000, 32'h0);
    wr(tcs_pkg::OFS_CMP_A, 32'h1234);
    rd_chk(tcs_pkg::OFS_CMP_A, cap_a_val);
  endtask : t_capture

  task t_wave_regs;
    wr(tcs_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0));
    // enables land at the completing edge; look once they have settled
    @(posedge clk_i);
    chk({30'h0, a_oe, b_oe}, 32'h3);
    apb(1'b0, tcs_pkg::OFS_COUNT, 32'h0);
    count_val = rd[15:0];
    rd_chk(tcs_pkg::OFS_COUNT, {16'h0, count_val});
    wr(tcs_pkg::OFS_CMP_A, {16'h0, count_val + 16'h0010});
    rd_chk(tcs_pkg::OFS_CMP_A, {16'h0, count_val + 16'h0010});
    wr(tcs_pkg::OFS_CMP_B, {16'h0, count_val + 16'h0020});
    rd_chk(tcs_pkg::OFS_CMP_B, {16'h0, count_val + 16'h0020});
    wr(tcs_pkg::OFS_CMP_C, {16'h0, count_val + 16'h0030});
    rd_chk(tcs_pkg::OFS_CMP_C, {16'h0, count_val + 16'h0030});
    apb(1'b0, tcs_pkg::OFS_SR, 32'h0);
  endtask : t_wave_regs

  // every action code in turn, toggle twice so both directions show
  task t_line_b(input logic ext);
    logic [1:0] acts [5];
    logic [4:0] ex;
    acts = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
    ex = 5'b00101;
    if (ext) wr(tcs_pkg::OFS_IER, 32'h80);
    for (int i = 0; i < 5; i++) begin
      if (ext) begin
        wr(tcs_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 2'h0, acts[i], 2'h0));
        u_line.drive(1'b0, 1'b0, 1'b1);
        u_line.drive(1'b0, 1'b0, 1'b0);
      end else begin
        wr(tcs_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, acts[i]));
      end
      chk({31'h0, irq}, {31'h0, ext});
      apb(1'b0, tcs_pkg::OFS_SR, 32'h0);
      chk(rd & 32'h00040080, {13'h0, ex[i], 10'h0, ext, 7'h0});
      chk({31'h0, b_o}, {31'h0, ex[i]});
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : t_line_b

  task t_mask;
    wr(tcs_pkg::OFS_IER, 32'h10);
    wr(tcs_pkg::OFS_IER, 32'h00);
    rd_chk(tcs_pkg::OFS_IMR, 32'h90);
    wr(tcs_pkg::OFS_IDR, 32'h00);
    rd_chk(tcs_pkg::OFS_IMR, 32'h90);
    wr(tcs_pkg::OFS_IDR, 32'h90);
    rd_chk(tcs_pkg::OFS_IMR, 32'h00);
    u_line.drive(1'b0, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, tcs_pkg::OFS_SR, 32'h0);
    chk(rd & 32'h80, 32'h80);
    u_line.drive(1'b0, 1'b0, 1'b0);
  endtask : t_mask

  // a full wrap passes every compare value and the overflow point
  task t_run;
    wr(tcs_pkg::OFS_CTRL, ctrl(1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 2'h0));
    repeat (65600) @(posedge clk_i);
    wr(tcs_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0));
    apb(1'b0, tcs_pkg::OFS_SR, 32'h0);
    chk(rd & 32'h000500FF, 32'h0004001D);
    chk({31'h0, b_o}, 32'h1);
  endtask : t_run

  // ************************************************************
  // sequence, watchdog and verdict
  // ************************************************************
  task conclude;
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_capture();
    t_wave_regs();
    t_line_b(1'b0);
    t_line_b(1'b1);
    t_mask();
    t_run();
    conclude();
  end

  // the wrap run dominates; this leaves a wide margin over it
  initial begin
    #(8 * 100000);
    miscompares++;
    conclude();
  end
endmodule : tcs_channel_tb

/* tb/tcs_line_model.sv */
`timescale 1ns/1ps

// ************************************************************
// far side of the two timer lines and the external event pin
// ************************************************************
module tcs_line_model (
  // clock
  input  wire logic clk_i,
  // channel drive
  input  wire logic line_a_i,
  input  wire logic line_a_oe_i,
  input  wire logic line_b_i,
  input  wire logic line_b_oe_i,
  // resolved pins
  output logic      pin_a_o,
  output logic      pin_b_o,
  output logic      evt_o
);
  logic drv_a_q;
  logic drv_b_q;

  // a driven line shows the channel's level, else the far side's own level
  assign pin_a_o = line_a_oe_i ? line_a_i : drv_a_q;
  assign pin_b_o = line_b_oe_i ? line_b_i : drv_b_q;

  initial begin
    drv_a_q = 1'b0;
    drv_b_q = 1'b0;
    evt_o   = 1'b0;
  end

  // levels change just after an edge, then settle past the synchronisers
  task drive(input logic a, input logic b, input logic e);
    @(posedge clk_i);
    drv_a_q <= a;
    drv_b_q <= b;
    evt_o   <= e;
    repeat (6) @(posedge clk_i);
  endtask : drive
endmodule : tcs_line_model
